/* rtl/smbus_ext_defs.vh */
// register map, field positions, reset values and timing for the smbus extension
`ifndef SMBUS_EXT_DEFS_VH
`define SMBUS_EXT_DEFS_VH

`define IDX_SMB_CTRL        4'h8
`define IDX_SEC_ADDR        4'h9
`define IDX_LT_HI           4'hA
`define IDX_LT_LO           4'hB

`define BIT_EARLY_ACK       7
`define BIT_ALERT_EN        6
`define BIT_SEC_ADDR_EN     5
`define BIT_TCK_SEL         4
`define BIT_LOW_TO_FLAG     3
`define BIT_IDLE_FLAG       2
`define BIT_HS_LOW_FLAG     1
`define BIT_HS_LOW_IE       0

`define RST_CTRL            8'h00
`define RST_SEC_ADDR        7'h00
`define RST_LT              16'h0000

`define ALERT_RESP_ADDR     7'h0C
`define TO_PRESCALE         64
`define HIGH_TO_SHIFT       9

`endif

/* rtl/smbus_timeout_and_address_ext.v */
// smbus extension: acknowledge timing, extra address match, bus timeouts, apb registers
//
// Function
// - early ack off: decision applies next byte
// - early ack on: written value acks current byte
// - alert enable matches alert response address
// - second enable matches second address register
// - timeout tick clock/64 or undivided clock
// - scl low timeout sets flag, write-1 clears
// - zero low limit disables low timeout
// - both lines high past limit/512 sets idle
// - scl high sda low past limit/512 flags
// - interrupt from that flag only when enabled
// - second address bits 7:1, bit0 reads 0
// - low limit from high and low bytes
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "smbus_ext_defs.vh"
module smbus_timeout_and_address_ext #(
   parameter LT_W = 16
) (
   input  wire        i_clk,
   input  wire        i_sys_rst,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   input  wire        i_scl,
   input  wire        i_sda,
   input  wire [6:0]  i_rx_addr,
   input  wire        i_rx_addr_valid,
   input  wire        i_byte_received,
   input  wire        i_ack_slot,
   input  wire        i_ack_value_wr,
   input  wire        i_transmit_acknowledge_value,
   output reg         o_addr_match,
   output reg         o_ack_drive,
   output reg         o_ack_hold,
   output wire        o_scl_high_sda_low_irq
);
   // ****************************************
   // apb slave
   // ****************************************
   reg        early_ack_control_r;
   reg        alert_response_match_en_r;
   reg        second_address_match_en_r;
   reg        timeout_clock_select_r;
   reg        scl_low_timeout_flag_r;
   reg        bus_idle_timeout_flag_r;
   reg        scl_high_sda_low_flag_r;
   reg        scl_high_sda_low_irq_en_r;
   reg [6:0]  smbus_default_address_r;
   reg [7:0]  low_timeout_value_hi_r;
   reg [7:0]  low_timeout_value_lo_r;
   wire [7:0] rst_ctrl = `RST_CTRL;

   wire [9:0] word_idx = i_paddr[11:2];
   wire       idx_hit  = (i_paddr[1:0] == 2'b00) && (word_idx[9:4] == 6'h00);
   wire [3:0] idx      = word_idx[3:0];
   wire       access   = i_psel && i_penable;
   wire       wr       = access && i_pwrite;
   wire       mapped   = idx_hit && ((idx == `IDX_SMB_CTRL) || (idx == `IDX_SEC_ADDR) ||
                                     (idx == `IDX_LT_HI) || (idx == `IDX_LT_LO));
   wire       wr_ctrl  = wr && idx_hit && (idx == `IDX_SMB_CTRL);

   assign o_pready  = 1'b1;
   assign o_pslverr = access && !mapped;

   wire [LT_W-1:0] programmed_low_limit = {low_timeout_value_hi_r, low_timeout_value_lo_r};

   wire [7:0] ctrl_rd = {early_ack_control_r, alert_response_match_en_r, second_address_match_en_r,
                         timeout_clock_select_r, scl_low_timeout_flag_r, bus_idle_timeout_flag_r,
                         scl_high_sda_low_flag_r, scl_high_sda_low_irq_en_r};

   reg [7:0] rd_byte;
   always @* begin
      case (idx)
         `IDX_SMB_CTRL: rd_byte = ctrl_rd;
         `IDX_SEC_ADDR: rd_byte = {smbus_default_address_r, 1'b0};
         `IDX_LT_HI:    rd_byte = low_timeout_value_hi_r;
         `IDX_LT_LO:    rd_byte = low_timeout_value_lo_r;
         default:       rd_byte = 8'h00;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite && idx_hit) begin
         o_prdata <= {24'h00_0000, rd_byte};
      end else if (i_psel && !i_penable) begin
         o_prdata <= 32'h0000_0000;
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         early_ack_control_r       <= rst_ctrl[`BIT_EARLY_ACK];
         alert_response_match_en_r <= rst_ctrl[`BIT_ALERT_EN];
         second_address_match_en_r <= rst_ctrl[`BIT_SEC_ADDR_EN];
         timeout_clock_select_r    <= rst_ctrl[`BIT_TCK_SEL];
         scl_high_sda_low_irq_en_r <= rst_ctrl[`BIT_HS_LOW_IE];
         smbus_default_address_r   <= `RST_SEC_ADDR;
         {low_timeout_value_hi_r, low_timeout_value_lo_r} <= `RST_LT;
      end else if (wr && idx_hit) begin
         case (idx)
            `IDX_SMB_CTRL: begin
               early_ack_control_r       <= i_pwdata[`BIT_EARLY_ACK];
               alert_response_match_en_r <= i_pwdata[`BIT_ALERT_EN];
               second_address_match_en_r <= i_pwdata[`BIT_SEC_ADDR_EN];
               timeout_clock_select_r    <= i_pwdata[`BIT_TCK_SEL];
               scl_high_sda_low_irq_en_r <= i_pwdata[`BIT_HS_LOW_IE];
            end
            `IDX_SEC_ADDR: smbus_default_address_r <= i_pwdata[7:1];
            `IDX_LT_HI:    low_timeout_value_hi_r  <= i_pwdata[7:0];
            `IDX_LT_LO:    low_timeout_value_lo_r  <= i_pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // timeout tick
   // ****************************************
   reg [5:0] presc_r;
   wire      presc_wrap = (presc_r == 6'd63);
   wire      tick       = timeout_clock_select_r | presc_wrap;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         presc_r <= 6'd0;
      end else begin
         presc_r <= presc_r + 6'd1;
      end
   end

   // ****************************************
   // timeout detectors
   // ****************************************
   wire [LT_W-1:0] high_limit = programmed_low_limit >> `HIGH_TO_SHIFT;
   wire            low_exp;
   wire            idle_exp;
   wire            hs_low_exp;

   timeout_detector #(.W(LT_W)) u_low (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_cond    (!i_scl),
      .i_tick    (tick),
      .i_limit   (programmed_low_limit),
      .o_expired (low_exp)
   );
   timeout_detector #(.W(LT_W)) u_idle (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_cond    (i_scl && i_sda),
      .i_tick    (tick),
      .i_limit   (high_limit),
      .o_expired (idle_exp)
   );
   timeout_detector #(.W(LT_W)) u_hs_low (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_cond    (i_scl && !i_sda),
      .i_tick    (tick),
      .i_limit   (high_limit),
      .o_expired (hs_low_exp)
   );

   reg low_exp_d_r;
   reg hs_low_exp_d_r;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         low_exp_d_r             <= 1'b0;
         hs_low_exp_d_r          <= 1'b0;
         scl_low_timeout_flag_r  <= 1'b0;
         bus_idle_timeout_flag_r <= 1'b0;
         scl_high_sda_low_flag_r <= 1'b0;
      end else begin
         low_exp_d_r             <= low_exp;
         hs_low_exp_d_r          <= hs_low_exp;
         bus_idle_timeout_flag_r <= idle_exp;
         // set wins over write-1 clear
         if (low_exp && !low_exp_d_r) begin
            scl_low_timeout_flag_r <= 1'b1;
         end else if (wr_ctrl && i_pwdata[`BIT_LOW_TO_FLAG]) begin
            scl_low_timeout_flag_r <= 1'b0;
         end
         if (hs_low_exp && !hs_low_exp_d_r) begin
            scl_high_sda_low_flag_r <= 1'b1;
         end else if (wr_ctrl && i_pwdata[`BIT_HS_LOW_FLAG]) begin
            scl_high_sda_low_flag_r <= 1'b0;
         end
      end
   end

   assign o_scl_high_sda_low_irq = scl_high_sda_low_flag_r && scl_high_sda_low_irq_en_r;

   // ****************************************
   // address match
   // ****************************************
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_addr_match <= 1'b0;
      end else if (i_rx_addr_valid) begin
         o_addr_match <= (alert_response_match_en_r && (i_rx_addr == `ALERT_RESP_ADDR)) ||
                         (second_address_match_en_r && (i_rx_addr == smbus_default_address_r));
      end else begin
         o_addr_match <= 1'b0;
      end
   end

   // ****************************************
   // acknowledge control
   // ****************************************
   reg pending_ack_r;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         pending_ack_r <= 1'b0;
         o_ack_drive   <= 1'b1;
         o_ack_hold    <= 1'b0;
      end else begin
         if (i_ack_value_wr) begin
            pending_ack_r <= i_transmit_acknowledge_value;
         end
         if (early_ack_control_r) begin
            // hold the ack slot until software writes its decision
            if (i_byte_received) begin
               o_ack_hold <= 1'b1;
            end else if (i_ack_value_wr && o_ack_hold) begin
               o_ack_hold  <= 1'b0;
               o_ack_drive <= !i_transmit_acknowledge_value;
            end
         end else begin
            o_ack_hold <= 1'b0;
            if (i_ack_slot) begin
               o_ack_drive <= !pending_ack_r;
            end
         end
      end
   end
endmodule

/* rtl/timeout_detector.v */
// one condition-duration detector for the timeout logic
`timescale 1ns/100ps
module timeout_detector #(
   parameter W = 16
) (
   input  wire         i_clk,
   input  wire         i_sys_rst,
   input  wire         i_cond,
   input  wire         i_tick,
   input  wire [W-1:0] i_limit,
   output reg          o_expired
);
   reg [W-1:0] cnt_r;

   // count ticks while the condition holds; restart when it drops
   always @(posedge i_clk) begin
      if (i_sys_rst || !i_cond || (i_limit == {W{1'b0}})) begin
         cnt_r     <= {W{1'b0}};
         o_expired <= 1'b0;
      end else if (i_tick) begin
         if (cnt_r >= i_limit) begin
            o_expired <= 1'b1;
         end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* tb/smbus_bus_model.sv */
// far side of the bus: line levels and shift engine events
`timescale 1ns/100ps
module smbus_bus_model (
   input  wire logic       i_clk,
   output logic            o_scl = 1'b1,
   output logic            o_sda = 1'b1,
   output logic [6:0]      o_addr = 7'h55,
   output logic            o_addr_valid = 1'b0,
   output logic            o_byte = 1'b0,
   output logic            o_slot = 1'b0
);
   task lines(input logic s, input logic d, input int n);
      @(posedge i_clk);
      {o_scl, o_sda} <= {s, d};
      repeat (n) @(posedge i_clk);
   endtask
   task addr(input logic [6:0] x);
      @(posedge i_clk);
      {o_addr, o_addr_valid} <= {x, 1'b1};
      @(posedge i_clk);
      {o_addr, o_addr_valid} <= {~x, 1'b0};
   endtask
   task pulse(input int w);
      @(posedge i_clk);
      {o_byte, o_slot} <= (w == 0) ? 2'b10 : 2'b01;
      @(posedge i_clk);
      {o_byte, o_slot} <= 2'b00;
   endtask
endmodule

/* tb/smbus_ext_properties.sv */
// port assertions for the smbus extension block
`timescale 1ns/100ps
module smbus_ext_checker (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire logic        i_scl,
   input wire logic        i_sda,
   input wire logic        i_rx_addr_valid,
   input wire logic        i_byte_received,
   input wire logic        i_ack_slot,
   input wire logic        i_ack_value_wr,
   input wire logic        i_transmit_acknowledge_value,
   input wire logic        o_addr_match,
   input wire logic        o_ack_drive,
   input wire logic        o_ack_hold,
   input wire logic        o_scl_high_sda_low_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire rd = i_psel && i_penable && !i_pwrite;
   property p_ack_release;
      o_ack_hold && i_ack_value_wr |=> !o_ack_hold && o_ack_drive == !$past(i_transmit_acknowledge_value);
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack hold not released");
   property p_hold_cause; $rose(o_ack_hold) |-> $past(i_byte_received); endproperty
   a_hold_cause: assert property (p_hold_cause) else $error("hold without byte");
   property p_drive_cause; $changed(o_ack_drive) |-> $past(i_ack_slot || i_ack_value_wr); endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("ack drive changed alone");
   property p_match_cause; o_addr_match |-> $past(i_rx_addr_valid); endproperty
   a_match_cause: assert property (p_match_cause) else $error("match without address");
   property p_sec_bit0; rd && i_paddr == 12'h024 |-> o_prdata[0] == 1'b0 && o_prdata[31:8] == 24'h0; endproperty
   a_sec_bit0: assert property (p_sec_bit0) else $error("address bit 0 not zero");
   property p_unmapped; i_psel && i_penable && i_paddr == 12'h030 |-> o_pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_irq_cause;
      $rose(o_scl_high_sda_low_irq) && !$past(i_psel && i_pwrite) |-> $past(i_scl && !i_sda, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without stuck data line");
   property p_idle_cause; rd && i_paddr == 12'h020 && o_prdata[2] |-> $past(i_scl && i_sda, 2); endproperty
   a_idle_cause: assert property (p_idle_cause) else $error("idle flag on busy bus");
   c_match: cover property (o_addr_match);
   c_hold: cover property (o_ack_hold && i_ack_value_wr);
   c_irq: cover property ($rose(o_scl_high_sda_low_irq));
endmodule
bind smbus_timeout_and_address_ext smbus_ext_checker chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .i_scl(i_scl), .i_sda(i_sda), .i_rx_addr_valid(i_rx_addr_valid), .i_byte_received(i_byte_received),
   .i_ack_slot(i_ack_slot), .i_ack_value_wr(i_ack_value_wr),
   .i_transmit_acknowledge_value(i_transmit_acknowledge_value), .o_addr_match(o_addr_match),
   .o_ack_drive(o_ack_drive), .o_ack_hold(o_ack_hold), .o_scl_high_sda_low_irq(o_scl_high_sda_low_irq));

/* tb/tb_top.sv */
// self-checking bench for the smbus extension block
`timescale 1ns/100ps
module tb_top;
   logic        i_clk, i_sys_rst = 1'b1, i_psel = 0, i_penable = 0, i_pwrite = 0, wr = 0, tav = 0, probe = 0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic        vd_r = 0, ad_r = 0;
   logic [6:0]  a;
   wire  [31:0] o_prdata;
   wire         o_pready, scl, sda, av, byt, slot, match, drive, irq;
   wire  [6:0]  ra;
   logic [31:0] q[$];
   int          mismatches = 0, n_compared = 0, k;
   smbus_timeout_and_address_ext uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(), .i_scl(scl), .i_sda(sda), .i_rx_addr(ra), .i_rx_addr_valid(av), .i_byte_received(byt),
      .i_ack_slot(slot), .i_ack_value_wr(wr), .i_transmit_acknowledge_value(tav), .o_addr_match(match),
      .o_ack_drive(drive), .o_ack_hold(), .o_scl_high_sda_low_irq(irq));
   smbus_bus_model bm (.i_clk(i_clk), .o_scl(scl), .o_sda(sda), .o_addr(ra), .o_addr_valid(av), .o_byte(byt),
      .o_slot(slot));
   initial begin
      i_clk = 0;
      forever #50 i_clk = ~i_clk;
   end
   // ****************
   // apb, ack write, expectation and end-of-run tasks
   // ****************
   task end_sim;
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
      @(posedge i_clk);
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, ad, 24'h0, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      k = 0;
      do @(posedge i_clk); while (o_pready !== 1'b1 && ++k < 20);
      if (k >= 20) begin
         mismatches++;
         end_sim();
      end
      {i_psel, i_penable} <= 2'b00;
   endtask
   task wrr(input logic [11:0] ad, input logic [7:0] d); apb(1'b1, ad, d); endtask
   task rd(input logic [11:0] ad, input logic [7:0] e); q.push_back({24'h0, e}); apb(1'b0, ad, 8'h00); endtask
   task ackw(input logic v, input logic e);
      @(posedge i_clk);
      {wr, tav} <= {1'b1, v};
      q.push_back({31'h0, e});
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task note(input logic e); q.push_back({31'h0, e}); endtask
   task irqchk(input logic e); note(e); @(posedge i_clk); probe <= 1'b1; @(posedge i_clk); probe <= 1'b0; endtask
   // ****************
   // result monitor
   // ****************
   always @(posedge i_clk) begin : mon
      logic        ev;
      logic [31:0] g, e;
      ev = 1'b1;
      if (i_psel && i_penable && o_pready && !i_pwrite) g = o_prdata;
      else if (vd_r) g = {31'h0, match};
      else if (ad_r) g = {31'h0, drive};
      else if (probe) g = {31'h0, irq};
      else ev = 1'b0;
      vd_r <= av;
      ad_r <= slot | wr;
      if (ev) begin
         e = q.pop_front();
         n_compared++;
         if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
         end
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      k = $urandom(14);
      a = 7'($urandom()) | 7'h40;
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(12'h020, 8'h00);
      rd(12'h028, 8'h00);
      rd(12'h030, 8'h00);
      wrr(12'h024, {a, 1'b1});
      rd(12'h024, {a, 1'b0});
      for (int m = 0; m < 4; m++) begin
         wrr(12'h020, {1'b0, m[1:0], 5'h10});
         note(m[1]); bm.addr(7'h0C);
         note(m[0]); bm.addr(a);
         note(1'b0); bm.addr(a ^ 7'h01);
      end
      ackw(1'b1, 1'b1);
      note(1'b0); bm.pulse(1);
      ackw(1'b0, 1'b0);
      note(1'b1); bm.pulse(1);
      wrr(12'h020, 8'h90);
      bm.pulse(0);
      ackw(1'b1, 1'b0);
      bm.pulse(0);
      ackw(1'b0, 1'b1);
      wrr(12'h020, 8'h10);
      bm.lines(0, 1, 40);
      rd(12'h020, 8'h10);
      wrr(12'h02C, 8'h08);
      bm.lines(0, 1, 5); bm.lines(1, 1, 1); bm.lines(0, 1, 5); bm.lines(1, 1, 2);
      rd(12'h020, 8'h10);
      bm.lines(0, 1, 20); bm.lines(1, 1, 1);
      rd(12'h020, 8'h18);
      wrr(12'h020, 8'h18);
      rd(12'h020, 8'h10);
      wrr(12'h02C, 8'h00);
      wrr(12'h028, 8'h04);
      bm.lines(1, 0, 10);
      rd(12'h020, 8'h12);
      irqchk(1'b0);
      wrr(12'h020, 8'h11);
      irqchk(1'b1);
      bm.lines(1, 1, 10);
      rd(12'h020, 8'h17);
      wrr(12'h020, 8'h13);
      rd(12'h020, 8'h15);
      irqchk(1'b0);
      bm.lines(0, 1, 1);
      rd(12'h020, 8'h11);
      wrr(12'h020, 8'h00);
      bm.lines(1, 0, 100);
      rd(12'h020, 8'h00);
      bm.lines(1, 0, 300);
      rd(12'h020, 8'h02);
      end_sim();
   end
endmodule
